// file: verilog/pio_pkg.sv
`default_nettype none
package pio_pkg;
  // Geometry
  localparam int PIO_PORT_W = 8;
  localparam int PIO_NPORT = 3;
  localparam int PIO_NRES = 6;
  localparam int PIO_AW = 8;
  localparam int PIO_DW = 32;

  // Address fields: kind of register in [6:4], port or slot in [3:2]
  localparam int ADDR_KIND_LSB = 4;
  localparam int ADDR_KIND_W = 3;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_W = 2;

  localparam logic [2:0] KIND_LATCH = 3'h0;
  localparam logic [2:0] KIND_INMODE = 3'h1;
  localparam logic [2:0] KIND_OUTMODE = 3'h2;
  localparam logic [2:0] KIND_DRIVE = 3'h3;
  localparam logic [2:0] KIND_SKIP = 3'h4;
  localparam logic [2:0] KIND_GLOBAL = 3'h5;

  localparam logic [1:0] GLB_SEL_A = 2'h0;
  localparam logic [1:0] GLB_SEL_B = 2'h1;
  localparam logic [1:0] GLB_IRQSEL = 2'h2;
  localparam logic [1:0] GLB_EVT = 2'h3;

  // crossbar_select_reg_a: bit 0 serial port, bits 1.. routed resources
  localparam int SELA_SERIAL = 0;
  localparam int SELA_RES_LSB = 1;
  // crossbar_select_reg_b
  localparam int SELB_XBAR_EN = 0;
  localparam int SELB_PUD = 1;
  localparam int SELB_W = 2;
  // ext_irq_pin_select_reg: two 3-bit pin numbers within port 0
  localparam int IRQ_NUM = 2;
  localparam int IRQSEL_W = 3;
  localparam int IRQ1_LSB = 4;
  localparam int IRQREG_W = 8;

  // Reset values per port, and IRQSEL_RST for the global pin select register
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] INMODE_RST = 8'hff;
  localparam logic [7:0] OUTMODE_RST = 8'h00;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic [7:0] SKIP_RST = 8'h00;
  localparam logic [7:0] IRQSEL_RST = 8'h00;

  // Fixed serial port pins (flat pin index, port 0)
  localparam int SER_TX_PIN = 4;
  localparam int SER_RX_PIN = 5;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// file: verilog/pio_xbar_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pio_xbar_if #(
  parameter int NPIN = 24,
  parameter int NRES = 6,
  parameter int RIW = 3
);
  logic [NPIN-1:0] skip;
  logic [NRES-1:0] res_en;
  logic serial_en;
  logic [NPIN-1:0] used;
  logic [NPIN-1:0][RIW-1:0] res_of;

  modport cfg (output skip, output res_en, output serial_en, input used, input res_of);
  modport dec (input skip, input res_en, input serial_en, output used, output res_of);
endinterface
`default_nettype wire

// file: verilog/pio_xbar_dec.sv
`timescale 1ns/1ps
`default_nettype none
module pio_xbar_dec #(
  parameter int NPIN = 24,
  parameter int NRES = 6,
  parameter int RIW = 3
) (
  pio_xbar_if.dec x
);
  import pio_pkg::*;

  logic [NPIN-1:0] taken;
  logic [NPIN-1:0] used;
  logic [NPIN-1:0][RIW-1:0] res_of;
  logic found;

  // Pure priority walk; the caller registers its effect on the pads
  always_comb begin
    taken = '0;
    used = '0;
    res_of = '0;
    found = 1'b0;
    if (x.serial_en) begin // see [R20]
      taken[SER_TX_PIN] = 1'b1;
      taken[SER_RX_PIN] = 1'b1;
    end
    for (int r = 0; r < NRES; r++) begin
      found = 1'b0;
      if (x.res_en[r]) begin
        for (int p = 0; p < NPIN; p++) begin
          if (!found && !taken[p] && !x.skip[p]) begin // see [R14] see [R16] see [R19]
            taken[p] = 1'b1;
            used[p] = 1'b1;
            res_of[p] = RIW'(r);
            found = 1'b1;
          end
        end
      end
    end
  end

  assign x.used = used;
  assign x.res_of = res_of;
endmodule
`default_nettype wire

// file: verilog/pio_port_top.sv
// Operation
// [R01] Port latch reads give the live pin state under any crossbar setup.
// [R02] Select registers choose which peripherals the crossbar routes to pins.
// [R03] After reset every cell is high impedance with weak pull-up on.
// [R04] Crossbar enable at 0 forces both drivers off on every pin.
// [R05] Analog input mode disables pull-up, output driver and input receiver.
// [R06] Pins in analog mode read back as 0.
// [R07] Software sets digital mode for peripheral, trigger and GPIO pins.
// [R08] Push-pull mode drives the pad high or low following the output value.
// [R09] Open-drain never drives high; 0 drives low, 1 releases the pad.
// [R10] Undriven digital pins get pull-up; pull-up off while driving low.
// [R11] Global pull-up disable at 1 turns every weak pull-up off.
// [R12] Digital pins read the real pad level, not the driven value.
// [R13] Per-port drive register selects high or low strength; low after reset.
// [R14] Skipped pins never receive a crossbar peripheral signal. Serial TX and RX still use pins 4 and 5 when these are skipped.
// [R15] Software skips GPIO pins and pins claimed outside the crossbar.
// [R16] Routed signals land only on crossbar pins whose skip bit is 0. The serial port ignores the skip bits of pins 4 and 5.
// [R17] Transitions on selected digital trigger pins raise an event or wake.
// [R18] Triggers work on skipped and routed pins, never on analog pins.
// [R19] Each selected resource takes, in priority, the lowest free unskipped pin.
// [R20] Serial transmit and receive stay fixed on port 0 pins 4 and 5.
// [R21] Configuration writes reach drivers, pull-ups and receivers next cycle.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pio_port_top #(
  parameter int NPORT = pio_pkg::PIO_NPORT,
  parameter int PW = pio_pkg::PIO_PORT_W,
  parameter int NRES = pio_pkg::PIO_NRES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [pio_pkg::PIO_AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [pio_pkg::PIO_DW-1:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [pio_pkg::PIO_AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [pio_pkg::PIO_DW-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [NPORT*PW-1:0] i_pad_in,
  output logic [NPORT*PW-1:0] o_pad_out,
  output logic [NPORT*PW-1:0] o_pad_oe_n,
  output logic [NPORT*PW-1:0] o_pullup_en,
  output logic [NPORT*PW-1:0] o_drive_high,
  output logic [NPORT*PW-1:0] o_rcv_en,
  input wire logic [NRES-1:0] i_res_out,
  output logic [NRES-1:0] o_res_in,
  input wire logic i_serial_tx,
  output logic o_serial_rx,
  output logic [pio_pkg::IRQ_NUM-1:0] o_ext_lvl,
  output logic [pio_pkg::IRQ_NUM-1:0] o_ext_evt,
  output logic o_wake
);
  import pio_pkg::*;

  localparam int NPIN = NPORT * PW;
  localparam int RIW = (NRES > 1) ? $clog2(NRES) : 1;

  logic [NPIN-1:0] latch_ff;
  logic [NPIN-1:0] inmode_ff;
  logic [NPIN-1:0] outmode_ff;
  logic [NPIN-1:0] drive_ff;
  logic [NPIN-1:0] skip_ff;
  logic [NRES:0] sel_a_ff;
  logic [SELB_W-1:0] sel_b_ff;
  logic [IRQREG_W-1:0] irqsel_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [PIO_DW-1:0] rdata_ff;
  logic [NPIN-1:0] pad_s1_ff;
  logic [NPIN-1:0] pad_s2_ff;
  logic [NPIN-1:0] pad_out_ff;
  logic [NPIN-1:0] pad_oe_n_ff;
  logic [NPIN-1:0] pullup_ff;
  logic [NPIN-1:0] drvhi_ff;
  logic [NPIN-1:0] rcv_ff;
  logic [NRES-1:0] res_in_ff;
  logic serial_rx_ff;
  logic [IRQ_NUM-1:0] ext_lvl_ff;
  logic [IRQ_NUM-1:0] ext_evt_ff;
  logic wake_ff;

  logic xbar_en;
  logic pud;
  logic serial_en;
  logic [NPIN-1:0] pin_read;
  logic [NPIN-1:0] nxt_pad_out;
  logic [NPIN-1:0] nxt_drive;
  logic [NRES-1:0] nxt_res_in;
  logic [IRQ_NUM-1:0] nxt_ext_lvl;
  logic [IRQ_NUM-1:0] nxt_ext_evt;

  pio_xbar_if #(.NPIN(NPIN), .NRES(NRES), .RIW(RIW)) xb ();

  assign xbar_en = sel_b_ff[SELB_XBAR_EN];
  assign pud = sel_b_ff[SELB_PUD];
  assign serial_en = sel_a_ff[SELA_SERIAL];

  assign xb.skip = skip_ff;
  assign xb.res_en = sel_a_ff[NRES:SELA_RES_LSB]; // see [R02]
  assign xb.serial_en = serial_en;

  pio_xbar_dec #(.NPIN(NPIN), .NRES(NRES), .RIW(RIW)) u_dec (
    .x(xb)
  );

  // Only the second stage is read; analog pins read as zero
  assign pin_read = pad_s2_ff & inmode_ff; // see [R01] see [R06] see [R12]

  // Write channel: address and data are taken together in one beat
  logic [ADDR_KIND_W-1:0] aw_kind;
  logic [ADDR_IDX_W-1:0] aw_idx;
  logic aw_port_ok;
  logic wr_fire;
  logic wr_hit;
  logic wr_lane;

  assign aw_kind = i_s_axi_awaddr[ADDR_KIND_LSB +: ADDR_KIND_W];
  assign aw_idx = i_s_axi_awaddr[ADDR_IDX_LSB +: ADDR_IDX_W];
  assign aw_port_ok = int'(aw_idx) < NPORT;
  assign o_s_axi_awready = i_ce && i_s_axi_wvalid && !bvalid_ff;
  assign o_s_axi_wready = i_ce && i_s_axi_awvalid && !bvalid_ff;
  assign wr_fire = i_ce && i_s_axi_awvalid && i_s_axi_wvalid && !bvalid_ff;
  assign wr_lane = i_s_axi_wstrb[0];

  always_comb begin
    if (aw_kind <= KIND_SKIP) begin
      wr_hit = aw_port_ok;
    end else if (aw_kind == KIND_GLOBAL) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Per-port configuration; takes effect on the pads one edge later
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      latch_ff <= {NPORT{LATCH_RST[PW-1:0]}};
      inmode_ff <= {NPORT{INMODE_RST[PW-1:0]}}; // see [R03]
      outmode_ff <= {NPORT{OUTMODE_RST[PW-1:0]}};
      drive_ff <= {NPORT{DRIVE_RST[PW-1:0]}}; // see [R13]
      skip_ff <= {NPORT{SKIP_RST[PW-1:0]}};
    end else if (wr_fire && wr_lane && aw_port_ok) begin // see [R21]
      if (aw_kind == KIND_LATCH) begin
        latch_ff[int'(aw_idx)*PW +: PW] <= i_s_axi_wdata[PW-1:0];
      end else if (aw_kind == KIND_INMODE) begin
        inmode_ff[int'(aw_idx)*PW +: PW] <= i_s_axi_wdata[PW-1:0];
      end else if (aw_kind == KIND_OUTMODE) begin
        outmode_ff[int'(aw_idx)*PW +: PW] <= i_s_axi_wdata[PW-1:0];
      end else if (aw_kind == KIND_DRIVE) begin
        drive_ff[int'(aw_idx)*PW +: PW] <= i_s_axi_wdata[PW-1:0]; // see [R13]
      end else if (aw_kind == KIND_SKIP) begin
        skip_ff[int'(aw_idx)*PW +: PW] <= i_s_axi_wdata[PW-1:0];
      end
    end
  end

  // Global configuration
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_a_ff <= '0;
      sel_b_ff <= '0; // see [R04]
      irqsel_ff <= IRQSEL_RST;
    end else if (wr_fire && wr_lane && aw_kind == KIND_GLOBAL) begin
      if (aw_idx == GLB_SEL_A) begin
        sel_a_ff <= i_s_axi_wdata[NRES:0]; // see [R02]
      end else if (aw_idx == GLB_SEL_B) begin
        sel_b_ff <= i_s_axi_wdata[SELB_W-1:0];
      end else if (aw_idx == GLB_IRQSEL) begin
        irqsel_ff <= i_s_axi_wdata[IRQREG_W-1:0];
      end
    end
  end

  // Write response
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (i_ce) begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp = bresp_ff;

  // Read channel
  logic [ADDR_KIND_W-1:0] ar_kind;
  logic [ADDR_IDX_W-1:0] ar_idx;
  logic ar_port_ok;
  logic rd_fire;
  logic rd_ok;
  logic [PIO_DW-1:0] rd_data;

  assign ar_kind = i_s_axi_araddr[ADDR_KIND_LSB +: ADDR_KIND_W];
  assign ar_idx = i_s_axi_araddr[ADDR_IDX_LSB +: ADDR_IDX_W];
  assign ar_port_ok = int'(ar_idx) < NPORT;
  assign o_s_axi_arready = i_ce && !rvalid_ff;
  assign rd_fire = i_ce && i_s_axi_arvalid && !rvalid_ff;

  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    if (ar_kind == KIND_LATCH && ar_port_ok) begin
      rd_data[PW-1:0] = pin_read[int'(ar_idx)*PW +: PW]; // see [R01]
    end else if (ar_kind == KIND_INMODE && ar_port_ok) begin
      rd_data[PW-1:0] = inmode_ff[int'(ar_idx)*PW +: PW];
    end else if (ar_kind == KIND_OUTMODE && ar_port_ok) begin
      rd_data[PW-1:0] = outmode_ff[int'(ar_idx)*PW +: PW];
    end else if (ar_kind == KIND_DRIVE && ar_port_ok) begin
      rd_data[PW-1:0] = drive_ff[int'(ar_idx)*PW +: PW];
    end else if (ar_kind == KIND_SKIP && ar_port_ok) begin
      rd_data[PW-1:0] = skip_ff[int'(ar_idx)*PW +: PW];
    end else if (ar_kind == KIND_GLOBAL && ar_idx == GLB_SEL_A) begin
      rd_data[NRES:0] = sel_a_ff;
    end else if (ar_kind == KIND_GLOBAL && ar_idx == GLB_SEL_B) begin
      rd_data[SELB_W-1:0] = sel_b_ff;
    end else if (ar_kind == KIND_GLOBAL && ar_idx == GLB_IRQSEL) begin
      rd_data[IRQREG_W-1:0] = irqsel_ff;
    end else if (ar_kind == KIND_GLOBAL && ar_idx == GLB_EVT) begin
      rd_data[IRQ_NUM-1:0] = ext_lvl_ff;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else if (i_ce) begin
      if (rd_fire) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        rdata_ff <= rd_data;
      end else if (i_s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign o_s_axi_rvalid = rvalid_ff;
  assign o_s_axi_rresp = rresp_ff;
  assign o_s_axi_rdata = rdata_ff;

  // Pad input synchroniser
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Reset to the pulled-up idle level so no false trigger edge follows reset
      pad_s1_ff <= '1;
      pad_s2_ff <= '1;
    end else if (i_ce) begin
      pad_s1_ff <= i_pad_in;
      pad_s2_ff <= pad_s1_ff;
    end
  end

  // Per-pin cell: pick the output value, then decide the drivers
  for (genvar p = 0; p < NPIN; p++) begin : g_cell
    logic val;
    always_comb begin
      if (serial_en && p == SER_TX_PIN) begin
        val = i_serial_tx; // see [R20]
      end else if (serial_en && p == SER_RX_PIN) begin
        val = 1'b1;
      end else if (xb.used[p]) begin
        val = i_res_out[xb.res_of[p]]; // see [R16]
      end else begin
        val = latch_ff[p];
      end
    end
    assign nxt_drive[p] = xbar_en && inmode_ff[p] // see [R04] see [R05]
      && (outmode_ff[p] || !val); // see [R08] see [R09]
    assign nxt_pad_out[p] = val;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pad_out_ff <= '1;
      pad_oe_n_ff <= '1; // see [R03]
      pullup_ff <= '1;
      drvhi_ff <= '0;
      rcv_ff <= '1;
    end else if (i_ce) begin // see [R21]
      pad_out_ff <= nxt_pad_out;
      pad_oe_n_ff <= ~nxt_drive;
      // Pull-up only while released, so no current flows against a low drive
      pullup_ff <= inmode_ff & ~nxt_drive & {NPIN{!pud}}; // see [R05] see [R10] see [R11]
      drvhi_ff <= drive_ff; // see [R13]
      rcv_ff <= inmode_ff; // see [R05]
    end
  end

  assign o_pad_out = pad_out_ff;
  assign o_pad_oe_n = pad_oe_n_ff;
  assign o_pullup_en = pullup_ff;
  assign o_drive_high = drvhi_ff;
  assign o_rcv_en = rcv_ff;

  // Pad levels back to the routed peripherals
  always_comb begin
    nxt_res_in = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (xb.used[p]) begin
        nxt_res_in[xb.res_of[p]] = pin_read[p];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      res_in_ff <= '0;
      serial_rx_ff <= 1'b1;
    end else if (i_ce) begin
      res_in_ff <= nxt_res_in;
      // Idle high when the serial port is not routed
      serial_rx_ff <= serial_en ? pin_read[SER_RX_PIN] : 1'b1; // see [R20]
    end
  end

  assign o_res_in = res_in_ff;
  assign o_serial_rx = serial_rx_ff;

  // Event triggers on port 0, independent of skip and crossbar routing
  for (genvar i = 0; i < IRQ_NUM; i++) begin : g_evt
    logic [IRQSEL_W-1:0] sel;
    assign sel = irqsel_ff[i*IRQ1_LSB +: IRQSEL_W];
    assign nxt_ext_lvl[i] = pin_read[sel]; // see [R18]
    // Gate on digital mode so a switch to analog does not fake an edge
    assign nxt_ext_evt[i] = (nxt_ext_lvl[i] ^ ext_lvl_ff[i]) && inmode_ff[sel]; // see [R17]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_lvl_ff <= '1;
      ext_evt_ff <= '0;
      wake_ff <= 1'b0;
    end else if (i_ce) begin
      ext_lvl_ff <= nxt_ext_lvl;
      ext_evt_ff <= nxt_ext_evt; // see [R17]
      wake_ff <= |nxt_ext_evt;
    end
  end

  assign o_ext_lvl = ext_lvl_ff;
  assign o_ext_evt = ext_evt_ff;
  assign o_wake = wake_ff;
endmodule
`default_nettype wire

// file: test/pio_port_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pio_port_props #(
  parameter int NPORT = 3,
  parameter int PW = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [NPORT*PW-1:0] o_pad_oe_n,
  input wire logic [NPORT*PW-1:0] o_pullup_en,
  input wire logic [NPORT*PW-1:0] o_drive_high,
  input wire logic [NPORT*PW-1:0] o_rcv_en,
  input wire logic o_wake
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // First edge after release still shows the reset state
  property p_rst_idle;
    $fell(i_rst) |-> &o_pad_oe_n && &o_pullup_en && &o_rcv_en && o_drive_high == '0;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("cell not idle after reset");
  property p_pu_low;
    (o_pullup_en & ~o_pad_oe_n) == '0;
  endproperty
  a_pu_low: assert property (p_pu_low) else $error("pull-up on while driving");
  property p_analog;
    (~o_rcv_en & (o_pullup_en | ~o_pad_oe_n)) == '0;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin still digital");
  property p_wr_ans;
    i_ce && i_s_axi_awvalid && i_s_axi_wvalid && o_s_axi_awready && o_s_axi_wready
      |=> o_s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write response");
  property p_wr_hold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("bvalid dropped early");
  property p_refuse;
    o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write taken during response");
  property p_rd_ans;
    i_ce && i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid ##1 1'b1;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read response");
  property p_rd_hold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data unstable");
  property p_rd_w;
    o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rd_w: assert property (p_rd_w) else $error("read data upper bits set");
  c_wake: cover property (o_wake);
  c_wr: cover property (o_s_axi_bvalid && i_s_axi_bready);
  c_rd: cover property (o_s_axi_rvalid && i_s_axi_rready);
endmodule
bind pio_port_top pio_port_props #(.NPORT(NPORT), .PW(PW)) u_pio_port_props (.*);
`default_nettype wire

// file: test/tb_pio_port_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pio_port_top;
  import pio_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rdv;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_ext_lvl, o_ext_evt, rsp;
  logic [23:0] i_pad_in = 24'hffffff, o_pad_out, o_pad_oe_n, o_pullup_en, o_drive_high, o_rcv_en;
  logic [5:0] i_res_out = 6'h00, o_res_in;
  logic i_serial_tx = 1'b0, o_serial_rx, o_wake;
  int n_fail = 0, tests_run = 0;
  bit got, gw;
  always #2.5 i_clk = ~i_clk;
  pio_port_top u_pio_port_top (.*);
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= {24'h0, d};
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    do @(posedge i_clk); while (!(o_s_axi_awready && o_s_axi_wready));
    i_s_axi_awvalid <= 1'b0;
    i_s_axi_wvalid <= 1'b0;
    i_s_axi_bready <= 1'b1;
    do @(posedge i_clk); while (o_s_axi_bvalid !== 1'b1);
    i_s_axi_bready <= 1'b0;
    rsp = o_s_axi_bresp;
  endtask
  task rd(input logic [7:0] a);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    do @(posedge i_clk); while (!o_s_axi_arready);
    i_s_axi_arvalid <= 1'b0;
    i_s_axi_rready <= 1'b1;
    do @(posedge i_clk); while (o_s_axi_rvalid !== 1'b1);
    i_s_axi_rready <= 1'b0;
    rdv = o_s_axi_rdata;
    rsp = o_s_axi_rresp;
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, 24'(e), rdv[23:0]);
  endtask
  // Config lands one edge after the write, pads need two sync edges more
  task st;
    repeat (4) @(posedge i_clk);
  endtask
  task evw(input int b);
    got = 1'b0;
    gw = 1'b0;
    repeat (12) begin
      @(posedge i_clk);
      if (o_ext_evt[b] === 1'b1) got = 1'b1;
      if (o_wake === 1'b1) gw = 1'b1;
    end
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk("oe_n", 24'hffffff, o_pad_oe_n);
    chk("pullup", 24'hffffff, o_pullup_en);
    chk("rcv", 24'hffffff, o_rcv_en);
    chk("drive", 24'h0, o_drive_high);
    for (logic [7:0] k = 8'h0; k < 8'hc; k += 8'h4) begin
      rc("in_mode", 8'h10 + k, INMODE_RST);
      rc("out_mode", 8'h20 + k, OUTMODE_RST);
      rc("drv_reg", 8'h30 + k, DRIVE_RST);
      rc("skip", 8'h40 + k, SKIP_RST);
    end
    rc("sel_b", 8'h54, 8'h00);
    // Push-pull low on port 0 must stay off until the crossbar is on
    wr(8'h00, 8'h00);
    wr(8'h20, 8'hff);
    st;
    chk("xoff", 24'hffffff, o_pad_oe_n);
    wr(8'h54, 8'h01);
    st;
    chk("pp_oe", 24'hffff00, o_pad_oe_n);
    chk("pp_pu", 24'hffff00, o_pullup_en);
    wr(8'h00, 8'ha5);
    st;
    chk("pp_out", 24'ha5, 24'(o_pad_out[7:0]));
    wr(8'h04, 8'h0f);
    st;
    chk("od_oe", 24'h0f, 24'(o_pad_oe_n[15:8]));
    chk("od_pu", 24'h0f, 24'(o_pullup_en[15:8]));
    wr(8'h54, 8'h03);
    st;
    chk("pud", 24'h0, o_pullup_en);
    wr(8'h54, 8'h01);
    wr(8'h34, 8'h81);
    st;
    chk("drv", 24'h81, 24'(o_drive_high[15:8]));
    // Port 2 driving low, then switched to analog
    wr(8'h28, 8'hff);
    wr(8'h08, 8'h00);
    st;
    chk("p2_drv", 24'h0, 24'(o_pad_oe_n[23:16]));
    wr(8'h18, 8'h00);
    i_pad_in <= 24'hff3cff;
    st;
    chk("an_oe", 24'hff, 24'(o_pad_oe_n[23:16]));
    chk("an_pu", 24'h0, 24'(o_pullup_en[23:16]));
    chk("an_rcv", 24'h0, 24'(o_rcv_en[23:16]));
    rc("an_rd", 8'h08, 8'h00);
    rc("pad_rd", 8'h04, 8'h3c);
    // Serial plus resources 0 to 2 with pins 0 and 3 skipped
    wr(8'h00, 8'h00);
    wr(8'h40, 8'h09);
    wr(8'h50, 8'h0f);
    i_res_out <= 6'h05;
    i_serial_tx <= 1'b1;
    st;
    chk("xb_a", 24'h72, 24'(o_pad_out[7:0]));
    i_res_out <= 6'h02;
    i_serial_tx <= 1'b0;
    i_pad_in <= 24'hff3c24;
    st;
    chk("xb_b", 24'h24, 24'(o_pad_out[7:0]));
    chk("res_in", 24'h02, 24'(o_res_in));
    chk("ser_rx", 24'h1, 24'(o_serial_rx));
    rc("xb_rd", 8'h00, 8'h24);
    // Triggers on pins 6 and 7; select change may pulse once, so let it pass
    wr(8'h58, 8'h76);
    st;
    st;
    i_pad_in[6] <= 1'b1;
    evw(0);
    chk("evt", 24'h1, 24'(got));
    chk("wake", 24'h1, 24'(gw));
    chk("lvl_pin", 24'h1, 24'(o_ext_lvl));
    rc("lvl", 8'h5c, 8'h01);
    // Watch from the switch to analog on, so the switch itself must not pulse
    wr(8'h10, 8'hbf);
    i_pad_in[6] <= 1'b0;
    evw(0);
    chk("an_evt", 24'h0, 24'(got));
    rd(8'h4c);
    chk("un_rsp", 24'(RESP_SLVERR), 24'(rsp));
    chk("un_dat", 24'h0, rdv[23:0]);
    wr(8'h60, 8'h01);
    chk("un_wr", 24'(RESP_SLVERR), 24'(rsp));
    wr(8'h5c, 8'hff);
    chk("ro_wr", 24'(RESP_OKAY), 24'(rsp));
    wrap_up;
  end
endmodule
`default_nettype wire
